// ---- src/sbd_pkg.sv ----
// Shared constants and types for the subtract-with-borrow and decrement-skip datapath
package sbd_pkg;

  // ==========================================================================
  // Widths
  localparam int DATA_W   = 8;
  localparam int NIBBLE_W = 4;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic              FLAG_RESET = 1'b0;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;

  // ==========================================================================
  // Decrement step and cycle figures
  localparam logic [DATA_W-1:0] DEC_STEP       = 8'h01;
  localparam int                SKIP_CYCLES    = 2;
  localparam int                NO_SKIP_CYCLES = 1;

  // ==========================================================================
  // Instructions served and sequencer states
  typedef enum logic [1:0]
  {
    subtract_with_borrow_to_acc,
    subtract_with_borrow_to_mem,
    decrement_skip_zero_mem,
    decrement_skip_zero_acc
  } op_code_e;

  typedef enum logic
  {
    ST_EXEC,
    ST_DUMMY
  } seq_state_e;

endpackage

// ---- src/sub_borrow_alu.sv ----
// Subtractor with borrow-in, giving difference, carry, aux carry and overflow
`timescale 1ns/1ps
module sub_borrow_alu
  import sbd_pkg::*;
#(
  parameter int W = DATA_W
)
(
  // Operands
  input  wire logic [W-1:0] minuend_in,
  input  wire logic [W-1:0] subtrahend_in,
  input  wire logic         borrow_in,
  // Results
  output logic      [W-1:0] diff_out,
  output logic              no_borrow_out,
  output logic              aux_no_borrow_out,
  output logic              overflow_out
);

  logic [W:0]        full_diff;
  logic [NIBBLE_W:0] low_diff;

  assign full_diff = {1'b0, minuend_in} - {1'b0, subtrahend_in} - {{W{1'b0}}, borrow_in};
  assign low_diff  = {1'b0, minuend_in[NIBBLE_W-1:0]}
                   - {1'b0, subtrahend_in[NIBBLE_W-1:0]}
                   - {{NIBBLE_W{1'b0}}, borrow_in};

  assign diff_out          = full_diff[W-1:0];
  // Carry is the inverse of the borrow out of the top bit
  assign no_borrow_out     = ~full_diff[W];
  assign aux_no_borrow_out = ~low_diff[NIBBLE_W];
  assign overflow_out      = (minuend_in[W-1] ^ subtrahend_in[W-1])
                           & (minuend_in[W-1] ^ full_diff[W-1]);

endmodule

// ---- src/subtract_borrow_and_decrement_skip.sv ----
// Datapath slice: subtract with borrow to acc or memory, decrement and skip if zero
// Notes on behaviour
// - Immediate subtract: accumulator minus operand minus inverted carry, back into accumulator.
// - After any subtract, carry is 0 on negative difference, else 1.
// - Both subtracts update overflow, zero, aux carry, carry, signed and compare flags.
// - Memory subtract: accumulator minus memory byte minus inverted carry, written to memory.
// - Memory decrement: byte minus one stored back; skip next when result zero.
// - A skip inserts one dummy cycle, so the instruction takes two cycles.
// - Accumulator decrement: byte minus one into accumulator, memory untouched, skip on zero.
// - Nonzero decrement result continues with next instruction, no skip, no dummy cycle.
`timescale 1ns/1ps
module subtract_borrow_and_decrement_skip
  import sbd_pkg::*;
#(
  parameter int DW = DATA_W
)
(
  // Clock and reset
  input  wire logic          core_clk_in,
  input  wire logic          rst_n_in,
  // Instruction from the sequencer; operand is the immediate or the memory byte
  input  wire logic          op_valid_in,
  input  op_code_e           op_code_in,
  input  wire logic [DW-1:0] operand_in,
  // Direct loads of accumulator and carry from other instructions
  input  wire logic          acc_load_in,
  input  wire logic [DW-1:0] acc_load_data_in,
  input  wire logic          carry_load_in,
  input  wire logic          carry_load_data_in,
  // Sequencer handshake
  output logic               op_ready_out,
  output logic               op_done_out,
  output logic               skip_out,
  output logic               dummy_cycle_out,
  // Data memory write
  output logic               mem_wr_out,
  output logic [DW-1:0]      mem_wdata_out,
  // Architectural state
  output logic [DW-1:0]      acc_out,
  output logic               carry_out,
  output logic               aux_carry_out,
  output logic               zero_out,
  output logic               overflow_out,
  output logic               signed_compare_out,
  output logic               compare_zero_out
);

  // ==========================================================================
  // Elaboration check
  if (DW != DATA_W)
  begin : g_width_check
    $error("DW must equal DATA_W; flag positions are fixed");
  end

  // ==========================================================================
  // Operand selection and subtractor
  logic          take;
  logic          is_dec;
  logic [DW-1:0] minuend;
  logic [DW-1:0] subtrahend;
  logic          borrow;
  logic [DW-1:0] diff;
  logic          nxt_carry;
  logic          nxt_aux;
  logic          nxt_ovf;
  logic          diff_zero;
  logic          do_skip;
  seq_state_e    state_ff;

  assign take   = op_valid_in & op_ready_out;
  assign is_dec = (op_code_in == decrement_skip_zero_mem)
                | (op_code_in == decrement_skip_zero_acc);

  assign minuend    = is_dec ? operand_in : acc_out;
  assign subtrahend = is_dec ? DEC_STEP   : operand_in;
  assign borrow     = is_dec ? 1'b0       : ~carry_out;

  sub_borrow_alu #(
    .W (DW)
  ) u_alu (
    .minuend_in        (minuend),
    .subtrahend_in     (subtrahend),
    .borrow_in         (borrow),
    .diff_out          (diff),
    .no_borrow_out     (nxt_carry),
    .aux_no_borrow_out (nxt_aux),
    .overflow_out      (nxt_ovf)
  );

  assign diff_zero = (diff == DATA_ZERO);
  assign do_skip   = take & is_dec & diff_zero;

  // ==========================================================================
  // Sequencer: one dummy cycle after a skipping decrement
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_ff     <= ST_EXEC;
      op_ready_out <= 1'b1;
    end
    else
    begin
      unique case (state_ff)
        ST_EXEC:
        begin
          if (do_skip)
          begin
            state_ff     <= ST_DUMMY;
            op_ready_out <= 1'b0;
          end
        end
        ST_DUMMY:
        begin
          state_ff     <= ST_EXEC;
          op_ready_out <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      op_done_out     <= 1'b0;
      skip_out        <= 1'b0;
      dummy_cycle_out <= 1'b0;
    end
    else
    begin
      op_done_out     <= take;
      skip_out        <= do_skip;
      dummy_cycle_out <= do_skip;
    end
  end

  // ==========================================================================
  // Data memory write
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      mem_wr_out    <= 1'b0;
      mem_wdata_out <= DATA_ZERO;
    end
    else
    begin
      mem_wr_out <= take & ((op_code_in == subtract_with_borrow_to_mem)
                          | (op_code_in == decrement_skip_zero_mem));
      if (take)
      begin
        mem_wdata_out <= diff;
      end
    end
  end

  // ==========================================================================
  // Accumulator; an accepted accumulator-target instruction wins over a direct load
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      acc_out <= ACC_RESET;
    end
    else if (take && ((op_code_in == subtract_with_borrow_to_acc)
                   || (op_code_in == decrement_skip_zero_acc)))
    begin
      acc_out <= diff;
    end
    else if (acc_load_in)
    begin
      acc_out <= acc_load_data_in;
    end
  end

  // ==========================================================================
  // Flags: set by subtracts, carry also by direct load; decrements leave every flag alone
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      carry_out          <= FLAG_RESET;
      aux_carry_out      <= FLAG_RESET;
      zero_out           <= FLAG_RESET;
      overflow_out       <= FLAG_RESET;
      signed_compare_out <= FLAG_RESET;
      compare_zero_out   <= FLAG_RESET;
    end
    else if (take && !is_dec)
    begin
      carry_out          <= nxt_carry;
      aux_carry_out      <= nxt_aux;
      zero_out           <= diff_zero;
      overflow_out       <= nxt_ovf;
      signed_compare_out <= nxt_ovf ^ diff[DW-1];
      compare_zero_out   <= diff_zero;
    end
    else if (carry_load_in)
    begin
      carry_out <= carry_load_data_in;
    end
  end

  // ==========================================================================
  // Checks
  logic take_sub_acc;
  logic take_sub_mem;
  logic take_dec;

  assign take_sub_acc = take & (op_code_in == subtract_with_borrow_to_acc);
  assign take_sub_mem = take & (op_code_in == subtract_with_borrow_to_mem);
  assign take_dec     = take & is_dec;

  sequence s_skip_then_resume;
    skip_out && dummy_cycle_out && !op_ready_out ##1 op_ready_out && !dummy_cycle_out;
  endsequence

  sequence s_plain_resume;
    op_done_out && !skip_out && !dummy_cycle_out && op_ready_out;
  endsequence

  property p_sub_acc_result;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    take_sub_acc |=> acc_out == DW'($past(acc_out) - $past(operand_in)
                                    - {{(DW-1){1'b0}}, ~$past(carry_out)});
  endproperty
  a_sub_acc_result: assert property (p_sub_acc_result) else $error("acc subtract wrong");

  property p_sub_carry;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (take && !is_dec) |=> carry_out == ({1'b0, $past(acc_out)}
      >= ({1'b0, $past(operand_in)} + {{DW{1'b0}}, ~$past(carry_out)}));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("carry after subtract wrong");

  property p_sub_zero_flags;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    take_sub_mem |=> zero_out == (mem_wdata_out == DATA_ZERO)
                     && compare_zero_out == zero_out
                     && signed_compare_out == (overflow_out ^ mem_wdata_out[DW-1]);
  endproperty
  a_sub_zero_flags: assert property (p_sub_zero_flags) else $error("subtract flags wrong");

  property p_sub_aux_ovf;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (take && !is_dec) |=> aux_carry_out == ({1'b0, $past(acc_out[NIBBLE_W-1:0])}
      >= ({1'b0, $past(operand_in[NIBBLE_W-1:0])} + {{NIBBLE_W{1'b0}}, ~$past(carry_out)}))
      && overflow_out == (($past(acc_out[DW-1]) ^ $past(operand_in[DW-1]))
         & ($past(acc_out[DW-1])
            ^ (mem_wr_out ? mem_wdata_out[DW-1] : acc_out[DW-1])));
  endproperty
  a_sub_aux_ovf: assert property (p_sub_aux_ovf) else $error("aux carry or overflow wrong");

  property p_sub_mem_result;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    take_sub_mem |=> mem_wr_out && acc_out == $past(acc_out)
      && mem_wdata_out == DW'($past(acc_out) - $past(operand_in)
                              - {{(DW-1){1'b0}}, ~$past(carry_out)});
  endproperty
  a_sub_mem_result: assert property (p_sub_mem_result) else $error("memory subtract wrong");

  property p_dec_mem;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    take && op_code_in == decrement_skip_zero_mem
      |=> mem_wr_out && mem_wdata_out == DW'($past(operand_in) - DEC_STEP)
          && skip_out == (mem_wdata_out == DATA_ZERO);
  endproperty
  a_dec_mem: assert property (p_dec_mem) else $error("memory decrement wrong");

  property p_skip_dummy;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    take_dec && operand_in == DEC_STEP |=> s_skip_then_resume;
  endproperty
  a_skip_dummy: assert property (p_skip_dummy) else $error("skip without dummy cycle");

  property p_dec_acc;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    take && op_code_in == decrement_skip_zero_acc
      |=> !mem_wr_out && acc_out == DW'($past(operand_in) - DEC_STEP)
          && carry_out == $past(carry_out) && zero_out == $past(zero_out);
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("acc decrement wrong");

  property p_no_skip;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    take_dec && operand_in != DEC_STEP |=> s_plain_resume;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("nonzero decrement skipped");

endmodule

// ---- testbench/data_mem_model.sv ----
// Behavioural data memory feeding the datapath its operand byte
`timescale 1ns/1ps
module data_mem_model
  import sbd_pkg::*;
(
  // Request side
  input  wire logic              clk_in,
  input  wire logic              req_in,
  input  wire logic              take_in,
  input  wire logic [3:0]        addr_in,
  // Write port from the datapath
  input  wire logic              wr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  // Read data to the datapath
  output logic      [DATA_W-1:0] rdata_out
);
  logic [DATA_W-1:0] mem [16];
  logic [3:0]        wr_addr_ff;
  // Off a request the byte is inverted, so a stale read never looks valid
  assign rdata_out = req_in ? mem[addr_in] : ~mem[addr_in];
  // Plain always so the bench may preload bytes
  always @(posedge clk_in)
  begin
    if (take_in)
      wr_addr_ff <= addr_in;
    if (wr_in)
      mem[wr_addr_ff] <= wdata_in;
  end
endmodule

// ---- testbench/test_subtract_borrow_and_decrement_skip.sv ----
// Self-checking bench for the subtract-with-borrow and decrement-skip slice
`timescale 1ns/1ps
module test_subtract_borrow_and_decrement_skip
  import sbd_pkg::*;
;
  // ==========
  // Stimulus and observed signals
  logic       clk = 0, rst_n = 0, valid = 0, acc_ld = 0, c_ld = 0, c_ld_d = 0;
  logic [7:0] acc_ld_d = 8'h00;
  logic [3:0] addr = 4'h0;
  op_code_e   op = subtract_with_borrow_to_acc;
  logic [7:0] operand, wdata, acc;
  logic       ready, done, skip, dummy, wr, c, ac, z, ov, sc, cz;
  int         num_errors = 0, total_checks = 0, cycles = 0, acc_m = 0, c_m = 0;
  int         mem_e [16];

  initial forever #10 clk = ~clk;

  subtract_borrow_and_decrement_skip subtract_borrow_and_decrement_skip_inst (
    .core_clk_in(clk), .rst_n_in(rst_n), .op_valid_in(valid), .op_code_in(op),
    .operand_in(operand), .acc_load_in(acc_ld), .acc_load_data_in(acc_ld_d),
    .carry_load_in(c_ld), .carry_load_data_in(c_ld_d), .op_ready_out(ready),
    .op_done_out(done), .skip_out(skip), .dummy_cycle_out(dummy), .mem_wr_out(wr),
    .mem_wdata_out(wdata), .acc_out(acc), .carry_out(c), .aux_carry_out(ac),
    .zero_out(z), .overflow_out(ov), .signed_compare_out(sc), .compare_zero_out(cz));

  data_mem_model data_mem_model_inst (
    .clk_in(clk), .req_in(valid), .take_in(valid & ready), .addr_in(addr),
    .wr_in(wr), .wdata_in(wdata), .rdata_out(operand));

  // ==========
  // Checking and closing
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard: the run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      conclude();
    end
  end

  task automatic poke(input int a, input int v);
    mem_e[a] = v;
    data_mem_model_inst.mem[a] = v[7:0];
  endtask

  task automatic load(input int a, input int cb);
    @(posedge clk);
    #1;
    acc_ld = 1;
    acc_ld_d = a[7:0];
    c_ld = 1;
    c_ld_d = cb[0];
    @(posedge clk);
    #1;
    acc_ld = 0;
    c_ld = 0;
    acc_m = a;
    c_m = cb;
    chk({acc, c}, {a[7:0], cb[0]});
  endtask

  // ==========
  // Reference model of one instruction, compared at every result
  task automatic run(input op_code_e o, input int a);
    int b, d, r, hb, v, w, s, cf, af, zf;
    b = mem_e[a];
    w = 0;
    s = 0;
    @(posedge clk);
    #1;
    valid = 1;
    op = o;
    addr = a[3:0];
    @(posedge clk);
    #1;
    valid = 0;
    op = op_code_e'($urandom_range(3));
    addr = 4'($urandom);
    if (o == subtract_with_borrow_to_acc || o == subtract_with_borrow_to_mem)
    begin
      d = acc_m - b - (1 - c_m);
      r = d & 255;
      hb = (acc_m % 16) - (b % 16) - (1 - c_m);
      v = ((acc_m ^ b) & (acc_m ^ r) & 128) != 0;
      c_m = d >= 0;
      af = hb >= 0;
      zf = r == 0;
    end
    else
    begin
      r = (b + 255) % 256;
      s = r == 0;
    end
    if (o == subtract_with_borrow_to_acc || o == decrement_skip_zero_acc)
      acc_m = r;
    else
    begin
      mem_e[a] = r;
      w = 1;
    end
    if (o < 2)
      chk({done, skip, dummy, wr, ready, acc, c, ac, z, ov, sc, cz},
          {5'b10001 | 5'(w << 1), 8'(acc_m), 1'(c_m), 1'(af), 1'(zf), 1'(v),
           1'(v ^ (r >> 7)), 1'(zf)});
    else
      chk({done, skip, dummy, wr, ready, acc},
          {1'b1, 1'(s), 1'(s), 1'(w), 1'(!s), 8'(acc_m)});
    if (w)
      chk(wdata, r);
    @(posedge clk);
    #1;
    chk({done, skip, dummy, wr, ready}, 5'b00001);
    chk(data_mem_model_inst.mem[a], mem_e[a]);
  endtask

  // ==========
  // Directed corners, then random traffic
  int       t_acc [6] = '{128, 0, 0, 5, 255, 16};
  int       t_c   [6] = '{1, 0, 1, 0, 1, 0};
  int       t_mv  [6] = '{1, 0, 1, 1, 0, 1};
  op_code_e t_op  [6] = '{subtract_with_borrow_to_acc, subtract_with_borrow_to_mem,
                          decrement_skip_zero_mem, decrement_skip_zero_acc,
                          decrement_skip_zero_mem, subtract_with_borrow_to_acc};

  initial
  begin
    void'($urandom(5));
    for (int i = 0; i < 16; i++)
      poke(i, $urandom_range(255));
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1;
    chk({ready, done, skip, dummy, wr, wdata, acc, c, ac, z, ov, sc, cz}, 27'h4000000);
    for (int i = 0; i < 6; i++)
    begin
      load(t_acc[i], t_c[i]);
      poke(i, t_mv[i]);
      run(t_op[i], i);
    end
    // Reuse of byte 2, written by the directed memory decrement, shows the written result is seen
    run(decrement_skip_zero_acc, 2);
    for (int i = 0; i < 80; i++)
    begin
      if ($urandom_range(3) == 0)
        load($urandom_range(255), $urandom_range(1));
      run(op_code_e'($urandom_range(3)), $urandom_range(15));
    end
    conclude();
  end
endmodule
